// ---- mabce_pkg.sv ----
// shared constants, types and register map of the bit/arith/call execution core
package mabce_pkg;

  // avalon slave geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_INSTR  = 10'h000;
  localparam logic [ADDR_W-1:0] OFS_WORK   = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 10'h008;
  localparam logic [ADDR_W-1:0] OFS_PCHB   = 10'h00C;
  localparam logic [ADDR_W-1:0] OFS_PC     = 10'h010;
  localparam logic [ADDR_W-1:0] OFS_STACK  = 10'h014;
  // file register window: address bit 9 set, word index in bits 8:2
  localparam int FILE_SEL_BIT = 9;
  localparam int FILE_IDX_LSB = 2;

  // core geometry
  localparam int FILE_AW     = 7;
  localparam int FILE_DEPTH  = 128;
  localparam int PC_W        = 11;
  localparam int PCHB_W      = 3;
  localparam int STACK_DEPTH = 8;

  // status register field positions
  localparam int ST_CARRY = 0;
  localparam int ST_HALF  = 1;
  localparam int ST_NULL  = 2;
  localparam int ST_SKIP  = 3;
  localparam int ST_BUSY  = 4;

  // reset values
  localparam logic [7:0]        RST_WORK = 8'h00;
  localparam logic [PC_W-1:0]   RST_PC   = 11'h000;
  localparam logic [PCHB_W-1:0] RST_PCHB = 3'h0;

  // opcode field encodings
  localparam logic [3:0] OP_NOP       = 4'h0;
  localparam logic [3:0] OP_ADD_IMM_C = 4'h1;
  localparam logic [3:0] OP_ADD_IMM   = 4'h2;
  localparam logic [3:0] OP_AND_FILE  = 4'h3;
  localparam logic [3:0] OP_AND_IMM   = 4'h4;
  localparam logic [3:0] OP_BIT_CLR   = 4'h5;
  localparam logic [3:0] OP_BIT_SET   = 4'h6;
  localparam logic [3:0] OP_TEST_SKIP = 4'h7;
  localparam logic [3:0] OP_CALL      = 4'h8;

  // instruction word as written to the instruction register, bits 22:0
  localparam int INSTR_W = 23;
  typedef struct packed {
    logic [7:0]         imm;
    logic [FILE_AW-1:0] faddr;
    logic [2:0]         bitsel;
    logic               dest;
    logic [3:0]         op;
  } mabce_instr_t;

  // datapath answer for one instruction
  typedef struct packed {
    logic [7:0] value;
    logic       carry_f;
    logic       half_f;
    logic       null_f;
    logic       upd_arith;
    logic       upd_null;
    logic       to_work;
    logic       to_file;
    logic       skip;
    logic       call;
  } mabce_alu_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_CALL2
  } mabce_state_t;

endpackage

// ---- mabce_alu.sv ----
// combinational datapath: adders, and, bit ops, skip test
`timescale 1ns/1ps
module mabce_alu
  import mabce_pkg::*;
(
  input  wire mabce_instr_t i_instr,
  input  wire logic [7:0]   i_work,
  input  wire logic [7:0]   i_fval,
  input  wire logic         i_carry,
  output mabce_alu_t        o_res
);

  // carry-in only for the with-carry add
  wire       cin   = (i_instr.op == OP_ADD_IMM_C) ? i_carry : 1'b0;
  wire [8:0] sum   = {1'b0, i_work} + {1'b0, i_instr.imm} + {8'h00, cin};
  wire [4:0] low   = {1'b0, i_work[3:0]} + {1'b0, i_instr.imm[3:0]} + {4'h0, cin};
  wire [7:0] mask  = 8'h01 << i_instr.bitsel;
  wire [7:0] and_f = i_work & i_fval;
  wire [7:0] and_i = i_work & i_instr.imm;

  // decode per opcode; unknown codes behave as a no-operation
  always_comb begin
    o_res         = '0;
    o_res.carry_f = sum[8];                  // RULE_12
    o_res.half_f  = low[4];                  // RULE_15
    case (i_instr.op)
      OP_ADD_IMM_C, OP_ADD_IMM: begin
        o_res.value     = sum[7:0];          // RULE_01 RULE_02
        o_res.upd_arith = 1'b1;
        o_res.upd_null  = 1'b1;
        o_res.to_work   = 1'b1;
      end
      OP_AND_FILE: begin
        o_res.value    = and_f;              // RULE_03
        o_res.upd_null = 1'b1;
        o_res.to_work  = ~i_instr.dest;      // RULE_04
        o_res.to_file  = i_instr.dest;       // RULE_04
      end
      OP_AND_IMM: begin
        o_res.value    = and_i;              // RULE_05
        o_res.upd_null = 1'b1;
        o_res.to_work  = 1'b1;
      end
      OP_BIT_CLR: begin
        o_res.value   = i_fval & ~mask;      // RULE_06
        o_res.to_file = 1'b1;
      end
      OP_BIT_SET: begin
        o_res.value   = i_fval | mask;       // RULE_07
        o_res.to_file = 1'b1;
      end
      OP_TEST_SKIP: begin
        o_res.skip = ~|(i_fval & mask);      // RULE_08
      end
      OP_CALL: begin
        o_res.call = 1'b1;
      end
      default: begin
        o_res.value = 8'h00;
      end
    endcase
    o_res.null_f = (o_res.value == 8'h00);   // RULE_15
  end

endmodule

// ---- mabce_fmem.sv ----
// 128 x 8 file register page, two read ports and one write port
`timescale 1ns/1ps
module mabce_fmem
  import mabce_pkg::*;
#(
  parameter int AW    = FILE_AW,
  parameter int DEPTH = FILE_DEPTH
) (
  input  wire logic          i_clk,
  input  wire logic [AW-1:0] i_raddr_a,
  output logic [7:0]         o_rdata_a,
  input  wire logic [AW-1:0] i_raddr_b,
  output logic [7:0]         o_rdata_b,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata
);

  // no reset: contents are undefined until software or the core writes them
  logic [7:0] mem [DEPTH];

  // asynchronous reads so operand fetch fits the single execute cycle
  assign o_rdata_a = mem[i_raddr_a];         // RULE_13
  assign o_rdata_b = mem[i_raddr_b];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

endmodule

// ---- mabce_core.sv ----
// execution core with avalon register slave, call stack and skip handling
`timescale 1ns/1ps
// How it works
// [RULE_01] add immediate with carry: work plus immediate plus carry into work, flags
// [RULE_02] add immediate: work plus immediate into work, arithmetic flags, one cycle
// [RULE_03] and with file register, only null flag updated, one cycle
// [RULE_04] destination bit zero writes work, one writes the file register
// [RULE_05] and immediate into work, only null flag updated, one cycle
// [RULE_06] bit clear forces the chosen file register bit low, flags untouched
// [RULE_07] bit set forces the chosen file register bit high, flags untouched
// [RULE_08] test skips the next instruction when the chosen bit is zero
// [RULE_09] skipped instruction is discarded and runs as a no-operation cycle
// [RULE_10] call pushes program counter plus one, takes two cycles
// [RULE_11] call target is high buffer bits 2:0 above the eight-bit address
// [RULE_12] carry flag is one exactly when an addition carried out
// [RULE_13] file operands use seven address bits, registers 0 to 127
// [RULE_14] high buffer register supplies upper program counter bits on call
// [RULE_15] null flag on zero result, half flag on carry out of bit three
module mabce_core
  import mabce_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RSTN,
  input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic              I_AVS_READ,
  input  wire logic              I_AVS_WRITE,
  input  wire logic [DATA_W-1:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]        I_AVS_BYTEENABLE,
  output logic [DATA_W-1:0]      O_AVS_READDATA,
  output logic                   O_AVS_WAITREQUEST
);

  localparam int SPW = $clog2(DEPTH);

  mabce_state_t        state_q;
  mabce_state_t        state_d;
  mabce_instr_t        instr_q;
  logic [7:0]          work_q;
  logic                carry_q;
  logic                half_q;
  logic                null_q;
  logic                skip_q;
  logic [PC_W-1:0]     pc_q;
  logic [PCHB_W-1:0]   pchb_q;
  logic [SPW-1:0]      sp_q;
  logic [PC_W-1:0]     stack [DEPTH];
  logic                wait_q;
  logic [DATA_W-1:0]   rdata_q;
  mabce_alu_t          res;
  logic [7:0]          fval_core;
  logic [7:0]          fval_bus;

  // bus decode; every access waits until the core is idle
  wire                 core_idle = (state_q == ST_IDLE);
  wire                 take      = (I_AVS_READ | I_AVS_WRITE) & wait_q & core_idle;
  wire                 wr        = take & I_AVS_WRITE & I_AVS_BYTEENABLE[0];
  wire                 sel_file  = I_AVS_ADDRESS[FILE_SEL_BIT];
  wire [FILE_AW-1:0]   bus_fidx  = I_AVS_ADDRESS[FILE_IDX_LSB +: FILE_AW];
  wire                 sel_instr = ~sel_file & (I_AVS_ADDRESS == OFS_INSTR);
  wire                 sel_work  = ~sel_file & (I_AVS_ADDRESS == OFS_WORK);
  wire                 sel_stat  = ~sel_file & (I_AVS_ADDRESS == OFS_STATUS);
  wire                 sel_pchb  = ~sel_file & (I_AVS_ADDRESS == OFS_PCHB);
  wire                 sel_pc    = ~sel_file & (I_AVS_ADDRESS == OFS_PC);
  wire                 sel_stack = ~sel_file & (I_AVS_ADDRESS == OFS_STACK);
  // the instruction word needs its three low lanes
  wire                 wr_instr  = wr & sel_instr & (&I_AVS_BYTEENABLE[2:0]);

  // execute phase; a pending skip turns the fetched word into a no-operation
  wire                 exec      = (state_q == ST_EXEC);
  wire mabce_instr_t   instr_eff = skip_q ? '0 : instr_q;          // RULE_09
  wire [SPW-1:0]       sp_top    = sp_q - SPW'(1);
  wire [PC_W-1:0]      pc_next   = pc_q + PC_W'(1);
  wire [PC_W-1:0]      call_tgt  = {pchb_q, instr_q.imm};          // RULE_11 RULE_14
  wire                 core_fwe  = exec & res.to_file;
  wire                 file_we   = core_fwe | (wr & sel_file);
  wire [FILE_AW-1:0]   file_wa   = core_fwe ? instr_q.faddr : bus_fidx;
  wire [7:0]           file_wd   = core_fwe ? res.value : I_AVS_WRITEDATA[7:0];
  wire [7:0]           status_rd = {3'h0, ~core_idle, skip_q, null_q, half_q, carry_q};

  // read mux; unmapped addresses read zero
  wire [DATA_W-1:0]    rd_mux    =
    sel_file  ? {24'h000000, fval_bus} :
    sel_instr ? {{(DATA_W-INSTR_W){1'b0}}, instr_q} :
    sel_work  ? {24'h000000, work_q} :
    sel_stat  ? {24'h000000, status_rd} :
    sel_pchb  ? {{(DATA_W-PCHB_W){1'b0}}, pchb_q} :
    sel_pc    ? {{(DATA_W-PC_W){1'b0}}, pc_q} :
    sel_stack ? {{(DATA_W-PC_W){1'b0}}, stack[sp_top]} :
    {DATA_W{1'b0}};

  mabce_alu u_alu (
    .i_instr (instr_eff),
    .i_work  (work_q),
    .i_fval  (fval_core),
    .i_carry (carry_q),
    .o_res   (res)
  );

  mabce_fmem u_fmem (
    .i_clk     (I_CLK),
    .i_raddr_a (instr_q.faddr),
    .o_rdata_a (fval_core),
    .i_raddr_b (bus_fidx),
    .o_rdata_b (fval_bus),
    .i_we      (file_we),
    .i_waddr   (file_wa),
    .i_wdata   (file_wd)
  );

  // sequencer: a new word starts execution, a call spends one more cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  state_d = wr_instr ? ST_EXEC : ST_IDLE;
      ST_EXEC:  state_d = res.call ? ST_CALL2 : ST_IDLE;     // RULE_10
      ST_CALL2: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // avalon answer: waitrequest drops for one cycle once the access is taken
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else if (take) begin
      wait_q  <= 1'b0;
      rdata_q <= I_AVS_READ ? rd_mux : '0;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  // sequencer state and fetched instruction
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q <= ST_IDLE;
      instr_q <= '0;
    end else begin
      state_q <= state_d;
      if (wr_instr) begin
        instr_q <= I_AVS_WRITEDATA[INSTR_W-1:0];
      end
    end
  end

  // working register: core result wins, bus writes only while idle
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      work_q <= RST_WORK;
    end else if (exec && res.to_work) begin
      work_q <= res.value;                                      // RULE_01 RULE_02 RULE_05
    end else if (wr && sel_work) begin
      work_q <= I_AVS_WRITEDATA[7:0];
    end
  end

  // flags; bit ops, test and call leave them alone
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      carry_q <= 1'b0;
      half_q  <= 1'b0;
      null_q  <= 1'b0;
    end else if (exec) begin
      if (res.upd_arith) begin
        carry_q <= res.carry_f;                                 // RULE_12
        half_q  <= res.half_f;                                  // RULE_15
      end
      if (res.upd_null) begin
        null_q  <= res.null_f;                                  // RULE_03 RULE_15
      end
    end else if (wr && sel_stat) begin
      carry_q <= I_AVS_WRITEDATA[ST_CARRY];
      half_q  <= I_AVS_WRITEDATA[ST_HALF];
      null_q  <= I_AVS_WRITEDATA[ST_NULL];
    end
  end

  // skip pending: set by a taken test, consumed by the next executed word
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      skip_q <= 1'b0;
    end else if (exec) begin
      skip_q <= res.skip;                                       // RULE_08 RULE_09
    end
  end

  // program counter, high buffer and stack pointer
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pc_q   <= RST_PC;
      pchb_q <= RST_PCHB;
      sp_q   <= '0;
    end else begin
      if (exec && !res.call) begin
        pc_q <= pc_next;
      end else if (state_q == ST_CALL2) begin
        pc_q <= call_tgt;                                       // RULE_11
      end else if (wr && sel_pc) begin
        pc_q <= I_AVS_WRITEDATA[PC_W-1:0];
      end
      if (wr && sel_pchb) begin
        pchb_q <= I_AVS_WRITEDATA[PCHB_W-1:0];                  // RULE_14
      end
      // circular stack: overflow overwrites the oldest entry
      if (exec && res.call) begin
        sp_q <= sp_q + SPW'(1);                                 // RULE_10
      end
    end
  end

  // return stack storage, written on the first call cycle
  always_ff @(posedge I_CLK) begin
    if (exec && res.call) begin
      stack[sp_q] <= pc_next;                                   // RULE_10
    end
  end

  assign O_AVS_READDATA    = rdata_q;
  assign O_AVS_WAITREQUEST = wait_q;

endmodule

// ---- mabce_chk.sv ----
// bus protocol and execution timing checks for the execution core
`timescale 1ns/1ps
module mabce_chk
  import mabce_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RSTN,
  input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic              I_AVS_READ,
  input  wire logic              I_AVS_WRITE,
  input  wire logic [DATA_W-1:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]        I_AVS_BYTEENABLE,
  input  wire logic [DATA_W-1:0] O_AVS_READDATA,
  input  wire logic              O_AVS_WAITREQUEST
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  // accepted instruction writes, split into call and the rest
  wire logic req     = I_AVS_READ | I_AVS_WRITE;
  wire logic ins_acc = !O_AVS_WAITREQUEST && I_AVS_WRITE && I_AVS_ADDRESS == OFS_INSTR
    && (&I_AVS_BYTEENABLE[2:0]);
  wire logic is_call = I_AVS_WRITEDATA[3:0] == OP_CALL;
  logic      last_test_q;

  // a call right after a test may be discarded, so its timing is left unchecked
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      last_test_q <= 1'b0;
    end else if (ins_acc) begin
      last_test_q <= (I_AVS_WRITEDATA[3:0] == OP_TEST_SKIP);
    end
  end

  a_wait_one_cycle: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_wait_has_req: assert property (!O_AVS_WAITREQUEST |-> $past(req))
    else $error("answer without a pending request");
  a_answer_bound: assert property (req && O_AVS_WAITREQUEST |-> ##[1:3] !O_AVS_WAITREQUEST)
    else $error("request not answered in time");
  a_write_clears_rdata: assert property (!O_AVS_WAITREQUEST && I_AVS_WRITE
    |-> O_AVS_READDATA == '0)
    else $error("read data not cleared by a write");
  a_rdata_holds: assert property (O_AVS_WAITREQUEST && $past(O_AVS_WAITREQUEST)
    |-> $stable(O_AVS_READDATA))
    else $error("read data moved between accesses");
  a_pc_width: assert property (
    !O_AVS_WAITREQUEST && I_AVS_READ && I_AVS_ADDRESS == OFS_PC
    |-> O_AVS_READDATA[DATA_W-1:PC_W] == '0)
    else $error("program counter wider than eleven bits");
  a_call_two_cycles: assert property (ins_acc && is_call && !last_test_q ##1 req
    |=> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("call did not take two cycles");
  a_plain_one_cycle: assert property (ins_acc && !is_call ##1 req
    |=> !O_AVS_WAITREQUEST)
    else $error("plain instruction took more than one cycle");

  c_call: cover property (ins_acc && is_call ##1 req);
  c_plain: cover property (ins_acc && !is_call ##1 req);
  c_skip: cover property (!O_AVS_WAITREQUEST && I_AVS_READ && I_AVS_ADDRESS == OFS_STATUS
    && O_AVS_READDATA[ST_SKIP]);
endmodule

bind mabce_core mabce_chk u_chk (
  .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST));

// ---- mabce_core_bench.sv ----
// self-checking bench for the execution core over its register bus
`timescale 1ns/1ps
module mabce_core_bench
  import mabce_pkg::*;
();
  logic              clk     = 1'b0;
  logic              rstn    = 1'b0;
  logic [ADDR_W-1:0] addr    = '0;
  logic              rd      = 1'b0;
  logic              wr      = 1'b0;
  logic [DATA_W-1:0] wdata   = '0;
  logic [3:0]        be      = 4'hF;
  logic [DATA_W-1:0] rdata;
  logic              waitreq;
  logic [DATA_W-1:0] rv;
  int                mismatches = 0;
  int                checked    = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  mabce_core dut (.I_CLK(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq));

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one access; b2b skips the idle edge so a read can follow a write at once
  // no cycle limit here: only the watchdog may end a wait for the answer
  task automatic acc(input bit w, input bit b2b, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    if (!b2b) @(posedge clk);
    addr <= a;
    wdata <= d;
    if (w) begin
      wr <= 1'b1;
    end else begin
      rd <= 1'b1;
    end
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rv = rdata;
    if (w) begin
      wr <= 1'b0;
    end else begin
      rd <= 1'b0;
    end
  endtask

  task automatic wrr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    acc(1'b0, 1'b0, a, '0);
    chk(rv, e);
  endtask

  // file register n sits in the upper window, one word each
  function automatic logic [ADDR_W-1:0] fa(input int n);
    return ADDR_W'(32'h200 + 4 * n);
  endfunction

  task automatic ex(input logic [3:0] op, input logic [7:0] imm, input logic [2:0] b = 3'h0,
                    input logic [6:0] f = 7'h00, input logic d = 1'b0);
    wrr(OFS_INSTR, {9'h0, imm, f, b, d, op});
  endtask

  task automatic summarize;
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdc(OFS_WORK, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    rdc(10'h018, 32'h0);
    // additions, the first one read straight after the instruction
    ex(OP_ADD_IMM, 8'h34);
    acc(1'b0, 1'b1, OFS_WORK, '0);
    chk(rv, 32'h34);
    rdc(OFS_STATUS, 32'h0);
    wrr(OFS_WORK, 32'h12);
    wrr(OFS_STATUS, 32'h1);
    ex(OP_ADD_IMM_C, 8'h34);
    rdc(OFS_WORK, 32'h47);
    rdc(OFS_STATUS, 32'h0);
    wrr(OFS_WORK, 32'h08);
    ex(OP_ADD_IMM, 8'hF8);
    rdc(OFS_WORK, 32'h0);
    rdc(OFS_STATUS, 32'h7);
    ex(OP_ADD_IMM_C, 8'hFF);
    rdc(OFS_WORK, 32'h0);
    rdc(OFS_STATUS, 32'h7);
    // half carry alone, carry with a zero result, half carry made by the carry-in
    wrr(OFS_WORK, 32'h08);
    ex(OP_ADD_IMM, 8'h08);
    rdc(OFS_WORK, 32'h10);
    rdc(OFS_STATUS, 32'h2);
    wrr(OFS_WORK, 32'h80);
    ex(OP_ADD_IMM, 8'h80);
    rdc(OFS_STATUS, 32'h5);
    wrr(OFS_STATUS, 32'h1);
    wrr(OFS_WORK, 32'h0F);
    ex(OP_ADD_IMM_C, 8'h00);
    rdc(OFS_WORK, 32'h10);
    rdc(OFS_STATUS, 32'h2);
    // and with immediate keeps carry and half
    wrr(OFS_WORK, 32'h5A);
    wrr(OFS_STATUS, 32'h3);
    ex(OP_AND_IMM, 8'hAF);
    rdc(OFS_WORK, 32'h0A);
    rdc(OFS_STATUS, 32'h3);
    ex(OP_AND_IMM, 8'h00);
    rdc(OFS_STATUS, 32'h7);
    // and with file register, both destinations
    wrr(fa(5), 32'hAF);
    wrr(OFS_WORK, 32'h5A);
    ex(OP_AND_FILE, 8'h00, 3'h0, 7'h05, 1'b1);
    rdc(fa(5), 32'h0A);
    rdc(OFS_WORK, 32'h5A);
    rdc(OFS_STATUS, 32'h3);
    wrr(fa(127), 32'hF0);
    wrr(OFS_WORK, 32'h0F);
    ex(OP_AND_FILE, 8'h00, 3'h0, 7'h7F, 1'b0);
    rdc(OFS_WORK, 32'h0);
    rdc(OFS_STATUS, 32'h7);
    // every bit position set, then cleared
    wrr(fa(3), 32'h0);
    for (int b = 0; b < 8; b++) begin
      ex(OP_BIT_SET, 8'h00, 3'(b), 7'h03);
      rdc(fa(3), (32'h1 << (b + 1)) - 1);
    end
    for (int b = 0; b < 8; b++) begin
      ex(OP_BIT_CLR, 8'h00, 3'(b), 7'h03);
      rdc(fa(3), 32'hFF & (32'hFF << (b + 1)));
    end
    rdc(OFS_STATUS, 32'h7);
    // skip taken discards the next word, then skip not taken
    wrr(fa(3), 32'h5A);
    wrr(OFS_PC, 32'h100);
    ex(OP_TEST_SKIP, 8'h00, 3'h2, 7'h03);
    rdc(OFS_STATUS, 32'hF);
    ex(OP_ADD_IMM, 8'h01);
    rdc(OFS_WORK, 32'h0);
    rdc(OFS_PC, 32'h102);
    ex(OP_TEST_SKIP, 8'h00, 3'h3, 7'h03);
    ex(OP_ADD_IMM, 8'h01);
    rdc(OFS_WORK, 32'h1);
    // call with a read straight behind it
    wrr(OFS_PCHB, 32'h5);
    wrr(OFS_PC, 32'h0A0);
    ex(OP_CALL, 8'h34);
    acc(1'b0, 1'b1, OFS_PC, '0);
    chk(rv, 32'h534);
    rdc(OFS_STACK, 32'h0A1);
    rdc(OFS_PCHB, 32'h5);
    // a skipped call is discarded: no push, no jump, just the step
    ex(OP_TEST_SKIP, 8'h00, 3'h2, 7'h03);
    ex(OP_CALL, 8'h77);
    rdc(OFS_PC, 32'h536);
    rdc(OFS_STACK, 32'h0A1);
    summarize();
  end

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
